/* hw/trig_seq_consts.svh */
// constants for the scan trigger sequencer: offsets, fields, reset values, timing
`ifndef TRIG_SEQ_CONSTS_SVH
`define TRIG_SEQ_CONSTS_SVH

// ------------
// register byte offsets
// ------------
`define OFS_CTRL      12'h000
`define OFS_ARM_CFG   12'h004
`define OFS_SCAN_CFG  12'h008
`define OFS_CHAN_CFG  12'h00C
`define OFS_COUNTS    12'h010
`define OFS_TIMING    12'h014
`define OFS_STATUS    12'h018

// ------------
// layer config fields: spacing[1:0], control[2], in_line[6:4], out_line[10:8]
// ------------
`define CFG_SPACING_LSB  0
`define CFG_CONTROL_BIT  2
`define CFG_IN_LSB       4
`define CFG_OUT_LSB      8
`define CHAN_MODE_BIT    12

// spacing codes
`define SPC_IMMEDIATE    2'h0
`define SPC_EXTERNAL     2'h1
`define SPC_BUS          2'h2

// ------------
// reset values
// ------------
`define ARM_CFG_RST      32'h0000_0000
`define SCAN_CFG_RST     32'h0000_0000
`define CHAN_CFG_RST     32'h0000_0104
`define ARM_COUNT_RST    8'h01
`define SCAN_COUNT_RST   8'h01
`define CHAN_COUNT_RST   8'h00

// ------------
// timing
// ------------
`define CLK_MHZ          25
`define SETTLE_US        10
`define SETTLE_CYC       (`SETTLE_US * `CLK_MHZ)
`define PULSE_NS         200
`define PULSE_CYC        ((`PULSE_NS * `CLK_MHZ + 999) / 1000)

`endif

/* hw/trig_seq_pkg.sv */
// types for the scan trigger sequencer
package trig_seq_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ARM_WAIT,
        ST_SCAN_WAIT,
        ST_CHAN_WAIT,
        ST_CLOSE,
        ST_SETTLE,
        ST_DELAY,
        ST_CHAN_OUT,
        ST_SCAN_OUT,
        ST_ARM_OUT
    } seq_state_t;

endpackage

/* hw/fall_detect.sv */
// synchroniser and falling-edge detector for one trigger input
`timescale 1ns/1ps
module fall_detect (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic line_i,
    output logic      fall_o
);
    // ------------
    // two-stage sync, then edge compare
    // ------------
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // idle level of a trigger line is high
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            prev_r <= 1'b1;
        end else begin
            meta_r <= line_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign fall_o = prev_r & ~sync_r;
endmodule // fall_detect

/* hw/scan_trigger_sequencer.sv */
// scan trigger sequencer: arm, scan and channel layers with APB settings
//
// What this block does
// - in bus mode each layer picks its input and output line from six; equal lines are refused except in the channel layer's single-line mode.
// - the bus has an asynchronous mode with separate lines and a single-line semi-synchronous mode.
// - bus pulses are the same low-going pulses used on the dedicated trigger pins.
// - a layer reacts to bus triggers only when its spacing selects the bus.
// - in the channel layer with bus spacing each input trigger closes the next channel.
// - after a close the block waits settle time, then the programmed delay, then pulses the output once.
// - scan and arm layers may use bus spacing with their own lines, which may equal the channel lines.
// - the scan or channel layer set to bypass skips its trigger wait on the first pass only; the arm layer always waits.
// - after an output pulse with channels left the block waits again for a trigger, bypass off.
// - with immediate arm and scan spacing the scan drops to the channel layer at once.
// - with external spacing each external input pulse closes a channel and the settled output pulses.
// - reset gives immediate arm and scan, arm count one, acceptor arm and scan, bypass channel, list length.
// - both bus ports share the same six lines.
// - with external spacing an output pulse follows every closed and settled channel.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "trig_seq_consts.svh"
module scan_trigger_sequencer import trig_seq_pkg::*; #(
    parameter int SETTLE_CYCLES = `SETTLE_CYC,
    parameter int PULSE_CYCLES  = `PULSE_CYC,
    parameter int LIST_LEN      = 10
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_trig_i,
    output logic             chan_ready_o,
    input  wire logic [5:0]  trigger_bus_event_i,
    output logic      [5:0]  trigger_bus_event_o,
    output logic      [5:0]  trigger_bus_event_oe_o,
    output logic             chan_close_o,
    output logic      [7:0]  chan_index_o,
    output logic             busy_o
);

    // ------------
    // register file
    // ------------
    logic [12:0] arm_cfg_r;
    logic [12:0] scan_cfg_r;
    logic [12:0] chan_cfg_r;
    logic [7:0]  arm_count_r;
    logic [7:0]  scan_count_r;
    logic [7:0]  chan_count_r;
    logic [23:0] delay_r;
    logic        cfg_err_r;
    logic        start_r;
    logic        abort_r;

    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        cfg_bad;
    seq_state_t  state_r;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign addr_ok = (paddr == `OFS_CTRL) || (paddr == `OFS_ARM_CFG) || (paddr == `OFS_SCAN_CFG)
                  || (paddr == `OFS_CHAN_CFG) || (paddr == `OFS_COUNTS) || (paddr == `OFS_TIMING)
                  || (paddr == `OFS_STATUS);

    // with bus spacing a line code outside 1..6, or in==out in asynchronous use, is refused
    function automatic logic line_bad(input logic [12:0] v, input logic single_ok);
        logic [2:0] il;
        logic [2:0] ol;
        il = v[`CFG_IN_LSB +: 3];
        ol = v[`CFG_OUT_LSB +: 3];
        line_bad = 1'b0;
        if (v[`CFG_SPACING_LSB +: 2] == `SPC_BUS) begin
            if (il == 3'h0 || il > 3'h6 || ol == 3'h0 || ol > 3'h6) begin
                line_bad = 1'b1;
            end else if (il == ol && !single_ok) begin
                line_bad = 1'b1;
            end
        end
    endfunction

    always_comb begin
        cfg_bad = 1'b0;
        if (paddr == `OFS_ARM_CFG || paddr == `OFS_SCAN_CFG) begin
            cfg_bad = line_bad(pwdata[12:0], 1'b0);
        end else if (paddr == `OFS_CHAN_CFG) begin
            cfg_bad = line_bad(pwdata[12:0], pwdata[`CHAN_MODE_BIT]);
        end
    end

    assign pslverr = psel & penable & (~addr_ok | (pwrite & cfg_bad));

    // settings are frozen while a scan runs
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            arm_cfg_r    <= 13'(`ARM_CFG_RST);
            scan_cfg_r   <= 13'(`SCAN_CFG_RST);
            chan_cfg_r   <= 13'(`CHAN_CFG_RST);
            arm_count_r  <= `ARM_COUNT_RST;
            scan_count_r <= `SCAN_COUNT_RST;
            chan_count_r <= `CHAN_COUNT_RST;
            delay_r      <= 24'h00_0000;
            cfg_err_r    <= 1'b0;
        end else if (wr_en && state_r == ST_IDLE) begin
            if (cfg_bad) begin
                cfg_err_r <= 1'b1;
            end else begin
                case (paddr)
                    `OFS_ARM_CFG:  arm_cfg_r  <= pwdata[12:0];
                    `OFS_SCAN_CFG: scan_cfg_r <= pwdata[12:0];
                    `OFS_CHAN_CFG: chan_cfg_r <= pwdata[12:0];
                    `OFS_COUNTS: begin
                        arm_count_r  <= pwdata[7:0];
                        scan_count_r <= pwdata[15:8];
                        chan_count_r <= pwdata[23:16];
                    end
                    `OFS_TIMING:   delay_r <= pwdata[23:0];
                    `OFS_STATUS:   cfg_err_r <= cfg_err_r & ~pwdata[0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_r <= 1'b0;
            abort_r <= 1'b0;
        end else begin
            start_r <= wr_en && paddr == `OFS_CTRL && pwdata[0];
            abort_r <= wr_en && paddr == `OFS_CTRL && pwdata[1];
        end
    end

    // ------------
    // trigger inputs
    // ------------
    logic [5:0] bus_fall;
    logic       ext_fall;

    // both bus ports land on one set of six lines, so one detector each
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_bus
            fall_detect u_fd (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .line_i  (trigger_bus_event_i[g]),
                .fall_o  (bus_fall[g])
            );
        end
    endgenerate

    fall_detect u_ext (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .line_i  (ext_trig_i),
        .fall_o  (ext_fall)
    );

    // pick the event for a layer from its spacing
    function automatic logic layer_event(input logic [12:0] v, input logic [5:0] bf, input logic ef);
        logic [2:0] il;
        il = v[`CFG_IN_LSB +: 3] - 3'h1;
        case (v[`CFG_SPACING_LSB +: 2])
            `SPC_IMMEDIATE: layer_event = 1'b1;
            `SPC_EXTERNAL:  layer_event = ef;
            `SPC_BUS:       layer_event = bf[il];
            default:        layer_event = 1'b0;
        endcase
    endfunction

    logic arm_ev;
    logic scan_ev;
    logic chan_ev;
    assign arm_ev  = layer_event(arm_cfg_r, bus_fall, ext_fall);
    assign scan_ev = layer_event(scan_cfg_r, bus_fall, ext_fall);
    assign chan_ev = layer_event(chan_cfg_r, bus_fall, ext_fall);

    // ------------
    // sequencer
    // ------------
    logic [7:0]  arm_done_r;
    logic [7:0]  scan_done_r;
    logic [7:0]  chan_done_r;
    logic        scan_first_r;
    logic        chan_first_r;
    logic [23:0] timer_r;
    logic [7:0]  chan_total;
    logic        out_req;
    logic [12:0] out_cfg;

    // count zero means use the scan list length
    assign chan_total = (chan_count_r == 8'h00) ? 8'(LIST_LEN) : chan_count_r;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r      <= ST_IDLE;
            arm_done_r   <= 8'h00;
            scan_done_r  <= 8'h00;
            chan_done_r  <= 8'h00;
            scan_first_r <= 1'b1;
            chan_first_r <= 1'b1;
            timer_r      <= 24'h00_0000;
        end else if (abort_r) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    // triggers are ignored here until a new start
                    if (start_r) begin
                        arm_done_r <= 8'h00;
                        state_r    <= ST_ARM_WAIT;
                    end
                end
                ST_ARM_WAIT: begin
                    if (arm_ev) begin
                        scan_done_r  <= 8'h00;
                        scan_first_r <= 1'b1;
                        state_r      <= ST_SCAN_WAIT;
                    end
                end
                ST_SCAN_WAIT: begin
                    if ((scan_first_r && scan_cfg_r[`CFG_CONTROL_BIT]) || scan_ev) begin
                        scan_first_r <= 1'b0;
                        chan_done_r  <= 8'h00;
                        chan_first_r <= 1'b1;
                        state_r      <= ST_CHAN_WAIT;
                    end
                end
                ST_CHAN_WAIT: begin
                    if ((chan_first_r && chan_cfg_r[`CFG_CONTROL_BIT]) || chan_ev) begin
                        chan_first_r <= 1'b0;
                        state_r      <= ST_CLOSE;
                    end
                end
                ST_CLOSE: begin
                    timer_r <= 24'(SETTLE_CYCLES);
                    state_r <= ST_SETTLE;
                end
                ST_SETTLE: begin
                    if (timer_r <= 24'h00_0001) begin
                        timer_r <= delay_r;
                        state_r <= ST_DELAY;
                    end else begin
                        timer_r <= timer_r - 24'h00_0001;
                    end
                end
                ST_DELAY: begin
                    if (timer_r == 24'h00_0000) begin
                        chan_done_r <= chan_done_r + 8'h01;
                        state_r     <= ST_CHAN_OUT;
                    end else begin
                        timer_r <= timer_r - 24'h00_0001;
                    end
                end
                ST_CHAN_OUT: begin
                    if (chan_done_r < chan_total) begin
                        state_r <= ST_CHAN_WAIT;
                    end else begin
                        scan_done_r <= scan_done_r + 8'h01;
                        state_r     <= ST_SCAN_OUT;
                    end
                end
                ST_SCAN_OUT: begin
                    if (scan_done_r < scan_count_r) begin
                        state_r <= ST_SCAN_WAIT;
                    end else begin
                        arm_done_r <= arm_done_r + 8'h01;
                        state_r    <= ST_ARM_OUT;
                    end
                end
                ST_ARM_OUT: begin
                    if (arm_done_r < arm_count_r) begin
                        state_r <= ST_ARM_WAIT;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ------------
    // output pulses
    // ------------
    // channel layer always pulses; scan/arm layers only when their source bypass is on and their spacing is not immediate
    always_comb begin
        out_req = 1'b0;
        out_cfg = chan_cfg_r;
        case (state_r)
            ST_CHAN_OUT: begin
                out_req = 1'b1;
                out_cfg = chan_cfg_r;
            end
            ST_SCAN_OUT: begin
                out_req = scan_cfg_r[`CFG_CONTROL_BIT] && scan_cfg_r[1:0] != `SPC_IMMEDIATE;
                out_cfg = scan_cfg_r;
            end
            ST_ARM_OUT: begin
                out_req = arm_cfg_r[`CFG_CONTROL_BIT] && arm_cfg_r[1:0] != `SPC_IMMEDIATE;
                out_cfg = arm_cfg_r;
            end
            default: ;
        endcase
    end

    logic [6:0]  pulse_drive;
    logic [2:0]  pulse_dst;
    assign pulse_dst = (out_cfg[1:0] == `SPC_BUS) ? out_cfg[`CFG_OUT_LSB +: 3] - 3'h1 : 3'h6;
    // one count per destination: a layer pulse right after a channel pulse on another destination leaves it whole; on the same one it reloads the count
    genvar d;
    generate
        for (d = 0; d < 7; d++) begin : g_pulse
            logic [15:0] cnt_r;
            logic        drv_r;
            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cnt_r <= 16'h0000;
                    drv_r <= 1'b0;
                end else if (out_req && pulse_dst == 3'(d)) begin
                    cnt_r <= 16'(PULSE_CYCLES);
                    drv_r <= 1'b1;
                end else begin
                    cnt_r <= (cnt_r > 16'h0001) ? cnt_r - 16'h0001 : 16'h0000;
                    drv_r <= (cnt_r > 16'h0001);
                end
            end
            assign pulse_drive[d] = drv_r;
        end
    endgenerate
    // low-going pulse, open drain on the shared lines
    assign trigger_bus_event_o    = 6'h00;
    assign trigger_bus_event_oe_o = pulse_drive[5:0];
    assign chan_ready_o           = ~pulse_drive[6];

    // ------------
    // status and readback
    // ------------
    logic close_r;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            close_r <= 1'b0;
        end else begin
            close_r <= (state_r == ST_CLOSE);
        end
    end
    assign chan_close_o = close_r;
    assign chan_index_o = chan_done_r;
    assign busy_o       = (state_r != ST_IDLE);

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `OFS_ARM_CFG:  prdata = {19'h0, arm_cfg_r};
                `OFS_SCAN_CFG: prdata = {19'h0, scan_cfg_r};
                `OFS_CHAN_CFG: prdata = {19'h0, chan_cfg_r};
                `OFS_COUNTS:   prdata = {8'h00, chan_count_r, scan_count_r, arm_count_r};
                `OFS_TIMING:   prdata = {8'h00, delay_r};
                `OFS_STATUS:   prdata = {chan_done_r, scan_done_r, arm_done_r, 3'h0, cfg_err_r, 4'(state_r)};
                default:       prdata = 32'h0000_0000;
            endcase
        end
    end
endmodule // scan_trigger_sequencer

/* sim/scan_trigger_sequencer_sva.sv */
// port assertions for the scan trigger sequencer
`timescale 1ns/1ps
`include "trig_seq_consts.svh"
module trig_seq_checker import trig_seq_pkg::*; #(
    parameter int SETTLE_CYCLES = 4
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        chan_ready_o,
    input wire logic [5:0]  trigger_bus_event_o,
    input wire logic [5:0]  trigger_bus_event_oe_o,
    input wire logic        chan_close_o,
    input wire logic        busy_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // ------------
    // helpers
    // ------------
    logic        cfg_wr;
    logic [15:0] since_close_r;
    assign cfg_wr = psel && penable && pwrite && paddr == `OFS_CHAN_CFG && !busy_o && pwdata[1:0] == `SPC_BUS;
    // saturates so an old close never looks recent
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            since_close_r <= 16'hFFFF;
        end else if (chan_close_o) begin
            since_close_r <= 16'h0000;
        end else if (since_close_r != 16'hFFFF) begin
            since_close_r <= since_close_r + 16'h0001;
        end
    end
    sequence low_pulse;
        !chan_ready_o [*5] ##1 chan_ready_o;
    endsequence
    sequence quiet_settle;
        (chan_ready_o && trigger_bus_event_oe_o == 6'h00) [*4];
    endsequence
    // ------------
    // assertions
    // ------------
    same_line_refused_a: assert property (
        cfg_wr && !pwdata[12] && pwdata[6:4] == pwdata[10:8] |-> pslverr) else $error("equal lines accepted");
    single_line_ok_a: assert property (
        cfg_wr && pwdata[12] && pwdata[6:4] == pwdata[10:8] && pwdata[6:4] inside {[1:6]} |-> !pslverr)
        else $error("single line setting refused");
    pulse_shape_a: assert property ($fell(chan_ready_o) |-> low_pulse) else $error("settled pulse width wrong");
    bus_pulse_a: assert property (
        $rose(trigger_bus_event_oe_o[0]) |-> trigger_bus_event_oe_o[0] [*5] ##1 !trigger_bus_event_oe_o[0])
        else $error("bus pulse width wrong");
    open_drain_a: assert property (trigger_bus_event_o == 6'h00) else $error("bus driven high");
    settle_quiet_a: assert property (chan_close_o |-> quiet_settle) else $error("output before settle");
    settle_count_a: assert property (
        $fell(chan_ready_o) |-> {16'h0000, since_close_r} >= SETTLE_CYCLES) else $error("settle too short");
    out_follows_a: assert property (
        chan_close_o |-> ##[5:60] (!chan_ready_o || trigger_bus_event_oe_o != 6'h00)) else $error("no output");
    idle_no_close_a: assert property (!busy_o |-> !chan_close_o) else $error("close while idle");
    start_busy_a: assert property (
        psel && penable && pwrite && paddr == `OFS_CTRL && pwdata[0] && !busy_o |-> ##[1:2] busy_o)
        else $error("start ignored");
endmodule // trig_seq_checker
bind scan_trigger_sequencer trig_seq_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .chan_ready_o(chan_ready_o),
    .trigger_bus_event_o(trigger_bus_event_o), .trigger_bus_event_oe_o(trigger_bus_event_oe_o),
    .chan_close_o(chan_close_o), .busy_o(busy_o));

/* sim/instrument_model.sv */
// measuring instrument model: answers each burst of output triggers with one pulse
`timescale 1ns/1ps
module instrument_model import trig_seq_pkg::*; #(
    parameter int LATENCY = 20
) (
    input  wire logic       clock_i,
    input  wire logic       rst_n_i,
    input  wire logic       ready_i,
    input  wire logic [5:0] bus_i,
    input  wire logic       use_bus_i,
    input  wire logic [5:0] listen_i,
    input  wire logic [5:0] reply_i,
    output logic            ext_trig_o,
    output logic [5:0]      bus_pull_o,
    output logic [7:0]      seen_o
);
    logic       ready_q;
    logic [5:0] bus_q;
    int         wait_cnt;
    logic       fire;
    // a second edge during the wait restarts it, so one reply per burst
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_q <= 1'b1;
            bus_q <= 6'h3F;
            wait_cnt <= 0;
            seen_o <= 8'h00;
            ext_trig_o <= 1'b1;
            bus_pull_o <= 6'h00;
        end else begin
            ready_q <= ready_i;
            bus_q <= bus_i;
            fire = use_bus_i ? |(bus_q & ~bus_i & listen_i) : (ready_q && !ready_i);
            if (fire) begin
                seen_o <= seen_o + 8'h01;
                wait_cnt <= LATENCY;
            end else if (wait_cnt > 0) begin
                wait_cnt <= wait_cnt - 1;
            end
            ext_trig_o <= use_bus_i || !(wait_cnt inside {[1:4]});
            bus_pull_o <= (use_bus_i && wait_cnt inside {[1:4]}) ? reply_i : 6'h00;
        end
    end
endmodule // instrument_model

/* sim/scan_trigger_sequencer_bench.sv */
// self-checking bench for the scan trigger sequencer
`timescale 1ns/1ps
`include "trig_seq_consts.svh"
module scan_trigger_sequencer_bench import trig_seq_pkg::*;;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, ext_trig_i, chan_ready_o, chan_close_o, busy_o, ext_m;
    logic        ext_b = 1'b1;
    logic        use_bus = 1'b0;
    logic [5:0]  bus_w, bus_o, oe_o, pull_m;
    logic [5:0]  pull_b = 6'h00;
    logic [5:0]  listen = 6'h00;
    logic [5:0]  reply = 6'h00;
    logic [7:0]  idx, seen;
    logic [31:0] q;
    logic        err;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          closes = 0;
    int          c0, n;
    // pulled-up open-drain lines: any party pulling wins
    assign bus_w = ~(oe_o | pull_m | pull_b);
    assign ext_trig_i = ext_m & ext_b;
    always #20 clock_i = ~clock_i;
    always @(posedge clock_i) if (chan_close_o === 1'b1) closes <= closes + 1;
    scan_trigger_sequencer #(.SETTLE_CYCLES(4)) u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_trig_i(ext_trig_i), .chan_ready_o(chan_ready_o), .trigger_bus_event_i(bus_w),
        .trigger_bus_event_o(bus_o), .trigger_bus_event_oe_o(oe_o), .chan_close_o(chan_close_o),
        .chan_index_o(idx), .busy_o(busy_o));
    instrument_model u_inst (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .ready_i(chan_ready_o), .bus_i(bus_w),
        .use_bus_i(use_bus), .listen_i(listen), .reply_i(reply), .ext_trig_o(ext_m),
        .bus_pull_o(pull_m), .seen_o(seen));
    // ------------
    // shared tasks
    // ------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge clock_i);
        end
        q = prdata;
        err = pslverr;
        check(32'(k < 20), 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock_i);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        check({31'h0, err}, {31'h0, e});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask
    task kick(input logic [5:0] m);
        pull_b <= m;
        ext_b <= (m != 6'h00);
        repeat (4) @(posedge clock_i);
        pull_b <= 6'h00;
        ext_b <= 1'b1;
        repeat (4) @(posedge clock_i);
    endtask
    task run(input int lim);
        c0 = closes;
        wr(`OFS_CTRL, 32'h0000_0001, 1'b0);
        repeat (2) @(posedge clock_i);
    endtask
    task wait_idle(input int lim);
        n = 0;
        while (busy_o !== 1'b0 && n < lim) begin
            n++;
            @(posedge clock_i);
        end
        check(32'(n < lim), 32'h1);
    endtask
    // ------------
    // scenarios
    // ------------
    task t_reset;
        rd(`OFS_ARM_CFG, `ARM_CFG_RST);
        rd(`OFS_SCAN_CFG, `SCAN_CFG_RST);
        rd(`OFS_CHAN_CFG, `CHAN_CFG_RST);
        rd(`OFS_COUNTS, {8'h00, `CHAN_COUNT_RST, `SCAN_COUNT_RST, `ARM_COUNT_RST});
        apb(1'b0, 12'h01C, 32'h0000_0000);
        check({31'h0, err}, 32'h1);
        check({30'h0, busy_o, chan_ready_o}, 32'h1);
        $display("test reset done");
    endtask
    task t_ext;
        wr(`OFS_CHAN_CFG, 32'h0000_0105, 1'b0);
        wr(`OFS_COUNTS, 32'h0003_0101, 1'b0);
        run(0);
        n = 0;
        while (closes == c0 && n < 10) begin
            n++;
            @(posedge clock_i);
        end
        check(32'(n < 8), 32'h1);
        wait_idle(600);
        check(32'(closes - c0), 32'h3);
        check({24'h0, idx}, 32'h3);
        check({24'h0, seen}, 32'h3);
        kick(6'h00);
        repeat (10) @(posedge clock_i);
        check(32'(closes - c0), 32'h3);
        $display("test external done");
    endtask
    task t_bus;
        use_bus <= 1'b1;
        listen <= 6'h01;
        reply <= 6'h02;
        wr(`OFS_CHAN_CFG, 32'h0000_0122, 1'b0);
        wr(`OFS_COUNTS, 32'h0002_0101, 1'b0);
        wr(`OFS_TIMING, 32'h0000_000A, 1'b0);
        run(0);
        kick(6'h00);
        repeat (10) @(posedge clock_i);
        check(32'(closes - c0), 32'h0);
        kick(6'h02);
        n = 0;
        while (oe_o[0] !== 1'b1 && n < 80) begin
            n++;
            @(posedge clock_i);
        end
        check(32'(n >= 8 && n < 80), 32'h1);
        wait_idle(800);
        check(32'(closes - c0), 32'h2);
        $display("test bus done");
    endtask
    task t_refuse;
        wr(`OFS_CHAN_CFG, 32'h0000_0332, 1'b1);
        wr(`OFS_CHAN_CFG, 32'h0000_0772, 1'b1);
        rd(`OFS_CHAN_CFG, 32'h0000_0122);
        apb(1'b0, `OFS_STATUS, 32'h0000_0000);
        check({31'h0, q[4]}, 32'h1);
        wr(`OFS_SCAN_CFG, 32'h0000_0222, 1'b1);
        wr(`OFS_CHAN_CFG, 32'h0000_1332, 1'b0);
        rd(`OFS_CHAN_CFG, 32'h0000_1332);
        $display("test refuse done");
    endtask
    task t_scan;
        listen <= 6'h05;
        wr(`OFS_CHAN_CFG, 32'h0000_0126, 1'b0);
        wr(`OFS_SCAN_CFG, 32'h0000_0326, 1'b0);
        wr(`OFS_COUNTS, 32'h0002_0201, 1'b0);
        wr(`OFS_TIMING, 32'h0000_0000, 1'b0);
        run(0);
        wait_idle(1200);
        check(32'(closes - c0), 32'h4);
        $display("test scan layer done");
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_reset();
        t_ext();
        t_bus();
        t_refuse();
        t_scan();
        conclude();
    end
endmodule // scan_trigger_sequencer_bench
